/* dv/flash_link_assertions.sv */
// Wire-level checks on the link between controller and device
`default_nettype none
module flash_link_assertions (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST_B,
  // Link wires
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // One serial clock half high, then low again
  sequence s_high_half;
    sclk [*8] ##1 !sclk;
  endsequence
  property p_sclk_high;
    $rose(sclk) |-> s_high_half;
  endproperty
  a_sclk_high: assert property (p_sclk_high)
    else $error("serial clock high half has wrong length");
  property p_sclk_low;
    $fell(sclk) |-> !sclk [*8];
  endproperty
  a_sclk_low: assert property (p_sclk_low)
    else $error("serial clock low half too short");
  // Mode 0: clock parked low outside frames
  property p_sclk_park;
    cs_n && $past(cs_n) |-> !sclk;
  endproperty
  a_sclk_park: assert property (p_sclk_park)
    else $error("serial clock moved outside a frame");
  property p_cs_start;
    $fell(cs_n) |-> !sclk [*8];
  endproperty
  a_cs_start: assert property (p_cs_start)
    else $error("first clock edge too close to select");
  // Gap lets the device close the frame before the next
  property p_cs_gap;
    $rose(cs_n) |-> cs_n [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("deselect gap too short");
  property p_dev_quiet;
    cs_n [*4] |-> dev_oe == 4'h0;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives while deselected");
  property p_dev_in_frame;
    $rose(|dev_oe) |-> !cs_n;
  endproperty
  a_dev_in_frame: assert property (p_dev_in_frame)
    else $error("device started driving outside a frame");
  // Single lane answers or all four, nothing else
  property p_dev_lanes;
    dev_oe inside {4'h0, 4'h2, 4'hf};
  endproperty
  a_dev_lanes: assert property (p_dev_lanes)
    else $error("device drives an odd lane set");
endmodule
`default_nettype wire

/* dv/test_flash_mode_and_power_commands.sv */
// Self-checking bench: controller and device joined over the link
`default_nettype none
module test_flash_mode_and_power_commands import flash_link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;       // System clock
  logic        rst_b;     // Sync reset, low active
  logic [7:0]  reg_addr;  // Register address
  logic [31:0] reg_wdata; // Register write data
  logic        reg_wr;    // Write strobe
  logic        reg_rd;    // Read strobe
  logic [31:0] reg_rdata; // Read data
  logic        irq;       // Controller interrupt
  logic        op_start;  // Array operation kick
  logic        op_busy, op_susp, dpd, qe, four, cont, hold_off;
  logic [31:0] rx;        // Last read value
  logic [31:0] st;        // Interrupt status of last job
  int          err_count; // Mismatches
  int          checked;   // Comparisons
  flash_link_if flash_link_if_i ();
  flash_cmd_host flash_cmd_host_i (.CLK_SYS(clk), .RST_B(rst_b),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq),
    .LINK(flash_link_if_i.host));
  // Long op so a status read still finds it running
  flash_cmd_device #(.OP_LEN(3000)) flash_cmd_device_i (.CLK_SYS(clk),
    .RST_B(rst_b), .LINK(flash_link_if_i.device), .OP_START(op_start),
    .OP_BUSY(op_busy), .OP_SUSPENDED(op_susp), .DEEP_POWER_DOWN(dpd),
    .QUAD_IO_ENABLE(qe), .FOUR_WIRE_MODE(four), .CONT_READ(cont),
    .HOLD_WP_DISABLED(hold_off));
  flash_link_assertions flash_link_assertions_i (.CLK_SYS(clk),
    .RST_B(rst_b), .sclk(flash_link_if_i.sclk),
    .cs_n(flash_link_if_i.cs_n), .dev_oe(flash_link_if_i.dev_oe));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rx = reg_rdata;
  endtask
  // One frame: launch, wait for the interrupt, clear, fetch bytes
  task automatic job(logic [31:0] c, logic [31:0] t0 = 32'h0);
    wr(8'h04, t0);
    wr(8'h00, c);
    repeat (8000)
      if (!irq) @(posedge clk);
    chk("irq", irq, 1'b1);
    rd(8'h14);
    st = rx;
    wr(8'h18, 32'h3);
    rd(8'h0c);
  endtask
  task automatic kick;
    @(posedge clk) op_start <= 1'b1;
    @(posedge clk) op_start <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst_b = 1'b0; reg_addr = 8'h0; reg_wdata = 32'h0;
    reg_wr = 1'b0; reg_rd = 1'b0; op_start = 1'b0;
    err_count = 0; checked = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    wr(8'h1c, 32'h3);
    job(32'h201, 32'h0002_0000);
    chk("qe", {qe, hold_off}, 2'b11);
    job(32'h835);
    chk("sr2", rx[1], 1'b1);
    // Masked interrupt stays low until enabled
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h805);
    repeat (600) @(posedge clk);
    chk("masked", irq, 1'b0);
    wr(8'h1c, 32'h3);
    @(posedge clk);
    #1 chk("unmasked", irq, 1'b1);
    wr(8'h18, 32'h3);
    rd(8'hfc);
    chk("unmapped", rx, 32'h0);
    $display("setup test done");
    kick;
    job(32'h805);
    chk("busy", rx[0], 1'b1);
    job(32'h75);
    chk("susp", {op_susp, op_busy}, 2'b10);
    job(32'h805);
    chk("susp rd", rx[0], 1'b0);
    job(32'h7a);
    chk("resume", {op_susp, op_busy}, 2'b01);
    job(32'h20805);
    chk("ready", {rx[0], op_busy}, 2'b00);
    $display("busy test done");
    job(32'h245a, 32'h0000_6400);
    chk("param", rx, 32'hf7a2d55c);
    job(32'h4deb, 32'ha5);
    chk("a5 in", {cont, rx[7:0]}, 9'h1ff);
    job(32'h40000);
    chk("fh out", cont, 1'b0);
    job(32'h4deb, 32'ha3);
    chk("ax in", cont, 1'b1);
    job(32'h14deb, 32'h0);
    chk("00 out", cont, 1'b0);
    $display("quad test done");
    job(32'h38);
    chk("4w on", four, 1'b1);
    job(32'h80ff);
    chk("ff off", four, 1'b0);
    job(32'h38);
    job(32'h8066);
    job(32'h8099);
    chk("6699 off", four, 1'b0);
    $display("four wire test done");
    job(32'hb9);
    chk("pd on", dpd, 1'b1);
    kick;
    job(32'h38);
    chk("pd deaf", {op_busy, four}, 2'b00);
    job(32'hab);
    chk("pd off", dpd, 1'b0);
    rd(8'h10);
    chk("guard", rx[2], 1'b1);
    repeat (300) @(posedge clk);
    rd(8'h10);
    chk("guard end", rx[2:0], 3'h2);
    $display("power test done");
    job(32'h201, 32'h0);
    chk("qe off", qe, 1'b0);
    job(32'h38);
    chk("refused", {st[1:0], four}, 3'b100);
    $display("refuse test done");
    finish_test;
  end
  // Whole run is well under half this span
  initial
  begin
    #500us;
    err_count++;
    finish_test;
  end
endmodule
`default_nettype wire

/* logic/flash_cmd_device.sv */
// Flash device end: mode, power and status command interpreter
// Function
// R1 - Resume suspended program on 7Ah
// R2 - Suspend on 75h, resume erase 7Ah
// R3 - Enter deep power-down on B9h
// R4 - Leave deep power-down on ABh
// R5 - Host waits 3 us after wake
// R6 - Deep power-down ignores all but wake
// R7 - Status byte one bit 0 is busy
// R8 - 35h returns quad enable at bit 1
// R9 - 01h second data byte bit 1 writes
// R10 - Quad enable frees hold and protect pins
// R11 - Mode byte Axh enters continuous quad read
// R12 - Mode byte 00h leaves continuous read
// R13 - Eight Fh clocks leave continuous read
// R14 - 38h enters four-wire mode if enabled
// R15 - FFh or 66h then 99h leaves it
// R16 - Parameter bytes F7 A2 D5 5C at 64h
//
// Decided for this implementation: the plain strobed port and the register offsets.
`default_nettype none
module flash_cmd_device
  import flash_link_pkg::*;
#(
  parameter int OP_LEN = OP_CYCLES
)(
  // System
  input  wire logic CLK_SYS,
  input  wire logic RST_B,
  // Link to the controller
  flash_link_if.device LINK,
  // Array operation side
  input  wire logic OP_START,
  output logic      OP_BUSY,
  output logic      OP_SUSPENDED,
  // Mode view
  output logic      DEEP_POWER_DOWN,
  output logic      QUAD_IO_ENABLE,
  output logic      FOUR_WIRE_MODE,
  output logic      CONT_READ,
  output logic      HOLD_WP_DISABLED
);
  localparam int OPW = $clog2(OP_LEN + 1);

  logic [5:0]     pin_s1;       // First sync stage
  logic [5:0]     pin_s2;       // Second sync stage
  logic           sclk_d;       // Delayed clock for edges
  logic           cs_d;         // Delayed select for edges
  logic           quad_io_enable_flag;
  logic           four_wire_command_mode;
  logic           cont;         // Continuous quad read armed
  logic           dpd;          // Deep power-down
  logic           reset_armed;  // 66h seen in last frame
  logic           suspended;    // Array operation halted
  logic [OPW-1:0] op_left;      // Remaining busy cycles
  logic [15:0]    nbits;        // Bits taken this frame
  logic [7:0]     opcode;       // Instruction of this frame
  logic [7:0]     rxsr;         // Receive shift
  logic [23:0]    addr;         // Received address
  logic [7:0]     second_status_byte;
  logic [7:0]     mode_byte;    // Quad read mode byte
  logic [7:0]     txsr;         // Transmit shift
  logic [3:0]     out_o;        // Lane values
  logic [3:0]     out_oe;       // Lane enables

  logic        sclk, cs_n, rise, fall, frame_start, frame_end;
  logic [3:0]  io_in;
  logic        w4, shift_ok, byte_done, rd_phase;
  logic [7:0]  nb, next_tx;
  logic [12:0] idx;
  logic        write_in_progress_flag;

  // Sampled pins, only the second stage is read
  assign sclk  = pin_s2[5];
  assign cs_n  = pin_s2[4];
  assign io_in = pin_s2[3:0];
  assign rise        = sclk & ~sclk_d & ~cs_n;
  assign fall        = ~sclk & sclk_d & ~cs_n;
  assign frame_start = ~cs_n & cs_d;
  assign frame_end   = cs_n & ~cs_d;
  assign idx = nbits[15:3];

  // Busy while counting, reads zero while suspended
  assign write_in_progress_flag = (op_left != '0) & ~suspended; // [R7]

  // Lane width: four-wire mode, or quad read past its opcode
  assign w4 = four_wire_command_mode
            | (opcode == OP_QUAD_READ && nbits >= ONE_BYTE_BITS);
  // Hold pauses shifting only while quad enable is clear
  assign shift_ok = quad_io_enable_flag | four_wire_command_mode
                  | io_in[3]; // [R10]
  assign nb = w4 ? {rxsr[3:0], io_in} : {rxsr[6:0], io_in[0]};
  assign byte_done = (nbits[2:0] | (w4 ? 3'b011 : 3'b000)) == 3'b111;

  // Parameter table lookup, other addresses read filler
  function automatic logic [7:0] param_byte(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - PARAM_BASE;
    if (rel < 8'h04)
      param_byte = PARAM_WORD[{rel[1:0], 3'b000} +: 8]; // [R16]
    else
      param_byte = PARAM_FILL;
  endfunction

  // Data phase of each read instruction
  always_comb
  begin
    rd_phase = 1'b0;
    if (!dpd)
    begin
      case (opcode)
        OP_READ_STATUS1,
        OP_READ_STATUS2: rd_phase = idx >= 13'(STATUS_DATA_BYTE);
        OP_PARAM_READ:   rd_phase = idx >= 13'(PARAM_DATA_BYTE);
        OP_QUAD_READ:    rd_phase = idx >= 13'(QUAD_DATA_BYTE);
        default:         rd_phase = 1'b0;
      endcase
    end
  end

  // Next transmit byte: fresh at a byte boundary, else shifted
  always_comb
  begin
    next_tx = w4 ? {txsr[3:0], 4'h0} : {txsr[6:0], 1'b0};
    if (nbits[2:0] == 3'b000)
    begin
      case (opcode)
        OP_READ_STATUS1:
          next_tx = {7'h00, write_in_progress_flag}; // [R7]
        OP_READ_STATUS2:
          next_tx = {6'h00, quad_io_enable_flag, 1'b0}; // [R8]
        OP_PARAM_READ:
          next_tx = param_byte(addr[7:0]
                    + 8'(idx - 13'(PARAM_DATA_BYTE))); // [R16]
        default:
          next_tx = ARRAY_FILL;
      endcase
    end
  end

  // Two-stage pin synchroniser and edge history
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      pin_s1 <= 6'h1f;
      pin_s2 <= 6'h1f;
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end
    else
    begin
      pin_s1 <= {LINK.sclk, LINK.cs_n, LINK.io};
      pin_s2 <= pin_s1;
      sclk_d <= sclk;
      cs_d   <= cs_n;
    end
  end

  // Frame receiver, sampled on rising serial clock
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      nbits              <= 16'h0000;
      opcode             <= 8'h00;
      rxsr               <= 8'h00;
      addr               <= 24'h000000;
      second_status_byte <= 8'h00;
      mode_byte          <= 8'h00;
    end
    else if (frame_start)
    begin
      // Continuous read frames start at the address
      if (cont && !dpd)
      begin
        nbits  <= ONE_BYTE_BITS; // [R11]
        opcode <= OP_QUAD_READ;
      end
      else
      begin
        nbits  <= 16'h0000; // [R12]
        opcode <= 8'h00;
      end
    end
    else if (rise && shift_ok)
    begin
      nbits <= nbits + (w4 ? 16'h0004 : 16'h0001);
      rxsr  <= nb;
      if (byte_done)
      begin
        // Opcode, address, status and mode bytes by position
        if (idx == 13'h0000)
          opcode <= nb;
        if (idx >= 13'h0001 && idx <= 13'(ADDR_LAST_BYTE))
          addr <= {addr[15:0], nb};
        if (idx == 13'(STATUS2_BYTE))
          second_status_byte <= nb; // [R9]
        if (idx == 13'(QUAD_MODE_BYTE))
          mode_byte <= nb;
      end
    end
  end

  // Transmitter, changed on falling serial clock
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      txsr   <= 8'h00;
      out_o  <= 4'h0;
      out_oe <= 4'h0;
    end
    else if (cs_n)
      out_oe <= 4'h0;
    else if (fall && rd_phase)
    begin
      txsr   <= next_tx;
      out_o  <= w4 ? next_tx[7:4] : {2'b00, next_tx[7], 1'b0};
      out_oe <= w4 ? 4'hf : 4'h2;
    end
  end

  // Mode and power changes, taken when the frame closes
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      quad_io_enable_flag    <= 1'b0;
      four_wire_command_mode <= 1'b0;
      cont                   <= 1'b0;
      dpd                    <= 1'b0;
      reset_armed            <= 1'b0;
      suspended              <= 1'b0;
    end
    else if (frame_end)
    begin
      reset_armed <= 1'b0;
      if (dpd)
      begin
        // Only a complete wake instruction is heard
        if (opcode == OP_WAKE && nbits == ONE_BYTE_BITS)
          dpd <= 1'b0; // [R4] [R6]
      end
      else if (nbits == ONE_BYTE_BITS)
      begin
        case (opcode)
          OP_SUSPEND:
            if (op_left != '0)
              suspended <= 1'b1; // [R2]
          OP_RESUME:
            suspended <= 1'b0; // [R1] [R2]
          OP_POWER_DOWN:
            dpd <= 1'b1; // [R3]
          OP_FOUR_WIRE_ON:
            if (quad_io_enable_flag)
              four_wire_command_mode <= 1'b1; // [R14]
          OP_FOUR_WIRE_OFF:
            four_wire_command_mode <= 1'b0; // [R15]
          OP_RESET_ARM:
            reset_armed <= 1'b1;
          OP_RESET_GO:
            if (reset_armed)
            begin
              four_wire_command_mode <= 1'b0; // [R15]
              cont                   <= 1'b0;
            end
          default:
            reset_armed <= 1'b0;
        endcase
      end
      else if (opcode == OP_WRITE_STATUS && nbits >= WRITE_STAT_BITS)
      begin
        // Protect pin blocks the write unless quad enable is set
        if (quad_io_enable_flag || io_in[2])
          quad_io_enable_flag <= second_status_byte[QE_BIT]; // [R9]
      end
      else if (opcode == OP_QUAD_READ && nbits >= QUAD_MODE_BITS)
      begin
        // Only Axh keeps it; 00h and an all-Fh mode byte end it
        cont <= quad_io_enable_flag
              && mode_byte[7:4] == MODE_ENTER_NIBBLE; // [R11] [R12] [R13]
      end
    end
  end

  // Array operation timer, frozen while suspended
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      op_left <= '0;
    else if (OP_START && op_left == '0 && !dpd)
      op_left <= OPW'(OP_LEN);
    else if (op_left != '0 && !suspended)
      op_left <= op_left - 1'b1; // [R2]
  end

  // Link and user side outputs
  assign LINK.dev_o       = out_o;
  assign LINK.dev_oe      = out_oe;
  assign OP_BUSY          = write_in_progress_flag;
  assign OP_SUSPENDED     = suspended;
  assign DEEP_POWER_DOWN  = dpd;
  assign QUAD_IO_ENABLE   = quad_io_enable_flag;
  assign FOUR_WIRE_MODE   = four_wire_command_mode;
  assign CONT_READ        = cont;
  assign HOLD_WP_DISABLED = quad_io_enable_flag; // [R10]
endmodule
`default_nettype wire

/* logic/flash_cmd_host.sv */
// Flash controller end: register driven frame sequencer
`default_nettype none
module flash_cmd_host
  import flash_link_pkg::*;
#(
  parameter int HALF = SCLK_HALF
)(
  // System
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  // Register port
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  output logic             IRQ,
  // Link to the device
  flash_link_if.host LINK
);
  host_state_t state;        // Sequencer state
  logic [31:0] job;          // Control word in flight
  logic [31:0] tx0, tx1;     // Staged transmit bytes
  logic [47:0] txsr;         // Transmit shift
  logic [31:0] rxsr;         // Receive shift
  logic [5:0]  cmd_bits;     // Opcode bits left
  logic [5:0]  tx_bits;      // Data bits left to send
  logic [5:0]  rx_bits;      // Data bits left to take
  logic [7:0]  div;          // Half period divider
  logic [8:0]  wait_cnt;     // Gap and guard counter
  logic        sclk, cs_n;
  logic        qe_shadow;    // Last quad enable written
  logic [1:0]  irq_stat, irq_en;
  logic [3:0]  in_s1, in_s2; // Lane synchroniser

  logic        tick, start_req, accept, relaunch, load, qe_need;
  logic        w4, rx_ph, last, ev_done;
  logic [31:0] nj;
  logic [5:0]  step;

  assign tick      = (div == 8'h00);
  assign start_req = REG_WR && REG_ADDR == REG_CTRL;
  // Quad use needs quad enable written first
  assign qe_need   = REG_WDATA[CTRL_QUAD_BIT] | REG_WDATA[CTRL_FOUR_BIT]
                   | REG_WDATA[CTRL_MRST_BIT]
                   | REG_WDATA[7:0] == OP_FOUR_WIRE_ON; // [R11] [R14]
  assign accept    = start_req && state == H_IDLE
                   && (!qe_need || qe_shadow);
  // Busy polling repeats 05h while bit 0 reads one
  assign relaunch  = state == H_GAP && tick && wait_cnt == 9'h000
                   && job[CTRL_POLL_BIT] && rxsr[WIP_BIT]; // [R7]
  assign load      = accept | relaunch;
  assign nj        = accept ? REG_WDATA : job;
  assign ev_done   = state == H_GAP && tick && wait_cnt == 9'h000
                   && !relaunch;
  assign w4    = cmd_bits != 6'h00 ? job[CTRL_FOUR_BIT]
               : (job[CTRL_FOUR_BIT] | job[CTRL_QUAD_BIT]
                  | job[CTRL_MRST_BIT]);
  assign rx_ph = cmd_bits == 6'h00 && tx_bits == 6'h00;
  assign step  = w4 ? 6'h04 : 6'h01;
  assign last  = (7'(cmd_bits) + 7'(tx_bits) + 7'(rx_bits)) == 7'(step);

  // Register reads answer one cycle later, zero otherwise
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B || !REG_RD)
      REG_RDATA <= 32'h0000_0000;
    else
    begin
      case (REG_ADDR)
        REG_TX0:      REG_RDATA <= tx0;
        REG_TX1:      REG_RDATA <= tx1;
        REG_RX:       REG_RDATA <= rxsr;
        REG_STATE:    REG_RDATA <= {29'h0, state == H_GUARD, qe_shadow,
                                    state != H_IDLE};
        REG_IRQ_STAT: REG_RDATA <= {30'h0, irq_stat};
        REG_IRQ_EN:   REG_RDATA <= {30'h0, irq_en};
        default:      REG_RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // Staging registers and quad enable shadow
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      tx0       <= 32'h0000_0000;
      tx1       <= 32'h0000_0000;
      irq_en    <= IRQ_RESET;
      qe_shadow <= 1'b0;
    end
    else
    begin
      if (REG_WR && REG_ADDR == REG_TX0)
        tx0 <= REG_WDATA;
      if (REG_WR && REG_ADDR == REG_TX1)
        tx1 <= REG_WDATA;
      if (REG_WR && REG_ADDR == REG_IRQ_EN)
        irq_en <= REG_WDATA[1:0];
      // Second data byte bit 1 carries the flag
      if (accept && REG_WDATA[7:0] == OP_WRITE_STATUS
          && REG_WDATA[CTRL_NTX_LSB +: 3] >= 3'h2)
        qe_shadow <= tx0[16 + QE_BIT]; // [R9]
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
      irq_stat <= IRQ_RESET;
    else
      irq_stat <= (irq_stat
                   & ~((REG_WR && REG_ADDR == REG_IRQ_CLR)
                       ? REG_WDATA[1:0] : 2'h0))
                  | {start_req && !accept, ev_done};
  end
  assign IRQ = |(irq_stat & irq_en);

  // Input lanes pass two flops before use
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      in_s1 <= 4'hf;
      in_s2 <= 4'hf;
    end
    else
    begin
      in_s1 <= LINK.io;
      in_s2 <= in_s1;
    end
  end

  // Frame sequencer: divider, clock, shifting and wait times
  always_ff @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      state    <= H_IDLE;
      job      <= 32'h0000_0000;
      txsr     <= 48'h0;
      rxsr     <= 32'h0000_0000;
      cmd_bits <= 6'h00;
      tx_bits  <= 6'h00;
      rx_bits  <= 6'h00;
      div      <= 8'h00;
      wait_cnt <= 9'h000;
      sclk     <= 1'b0;
      cs_n     <= 1'b1;
    end
    else
    begin
      div <= tick ? 8'(HALF - 1) : div - 8'h01;
      if (load)
      begin
        // Mode reset clocks Fh on all lanes for 8 clocks
        job      <= nj;
        state    <= H_RUN;
        cs_n     <= 1'b0;
        div      <= 8'(HALF - 1);
        cmd_bits <= (nj[CTRL_SKIP_BIT] | nj[CTRL_MRST_BIT])
                    ? 6'h00 : 6'h08;
        tx_bits  <= nj[CTRL_MRST_BIT] ? 6'h20
                    : {nj[CTRL_NTX_LSB +: 3], 3'b000}; // [R13]
        rx_bits  <= nj[CTRL_MRST_BIT] ? 6'h00
                    : {nj[CTRL_NRX_LSB +: 3], 3'b000};
        txsr     <= nj[CTRL_MRST_BIT] ? 48'hffff_ffff_ffff // [R13]
                  : nj[CTRL_SKIP_BIT] ? {tx0, tx1[7:0], 8'h00}
                  : {nj[7:0], tx0, tx1[7:0]};
      end
      else
      begin
        unique case (state)
          H_IDLE:
            sclk <= 1'b0;
          H_RUN:
            if (tick && !sclk)
            begin
              // Rising edge: sample lanes during the read phase
              sclk <= 1'b1;
              if (rx_ph)
                rxsr <= w4 ? {rxsr[27:0], in_s2}
                           : {rxsr[30:0], in_s2[1]};
            end
            else if (tick)
            begin
              // Falling edge: advance the active phase
              sclk <= 1'b0;
              if (cmd_bits != 6'h00)
                cmd_bits <= cmd_bits - step;
              else if (tx_bits != 6'h00)
                tx_bits <= tx_bits - step;
              else
                rx_bits <= rx_bits - step;
              txsr <= w4 ? {txsr[43:0], 4'h0} : {txsr[46:0], 1'b0};
              if (last)
              begin
                cs_n     <= 1'b1;
                state    <= H_GAP;
                wait_cnt <= 9'(CS_GAP_TICKS);
              end
            end
          H_GAP:
            if (tick && wait_cnt != 9'h000)
              wait_cnt <= wait_cnt - 9'h001;
            else if (tick)
            begin
              // After a wake, hold off every request for 3 us
              if (job[7:0] == OP_WAKE && !job[CTRL_SKIP_BIT])
              begin
                state    <= H_GUARD;
                wait_cnt <= 9'(WAKE_CYC); // [R5]
              end
              else
                state <= H_IDLE;
            end
          H_GUARD:
            if (wait_cnt != 9'h000)
              wait_cnt <= wait_cnt - 9'h001; // [R5]
            else
              state <= H_IDLE;
        endcase
      end
    end
  end

  // Lane drive: hold and protect stay high on single lane frames
  assign LINK.sclk    = sclk;
  assign LINK.cs_n    = cs_n;
  assign LINK.host_o  = w4 ? txsr[47:44] : {2'b11, 1'b0, txsr[47]};
  assign LINK.host_oe = (w4 && state == H_RUN && rx_ph) ? 4'h0
                      : w4 && state == H_RUN ? 4'hf : 4'hd;
endmodule
`default_nettype wire

/* logic/flash_link_if.sv */
// Link wires between the flash controller and the flash device
`default_nettype none
interface flash_link_if;
  logic       sclk;     // Serial clock, host driven
  logic       cs_n;     // Chip select, active low
  logic [3:0] host_o;   // Host lane values
  logic [3:0] host_oe;  // Host lane enables
  logic [3:0] dev_o;    // Device lane values
  logic [3:0] dev_oe;   // Device lane enables
  logic [3:0] io;       // Resolved quad_data_lines
  // Device wins, then host, else pulled high
  assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o)
            | (~dev_oe & ~host_oe);
  modport host   (output sclk, cs_n, host_o, host_oe, input io);
  modport device (input sclk, cs_n, io, output dev_o, dev_oe);
endinterface
`default_nettype wire

/* logic/flash_link_pkg.sv */
// Shared constants and types for the flash command link, both ends
`default_nettype none
package flash_link_pkg;
  // Instruction codes
  localparam logic [7:0] OP_READ_STATUS1  = 8'h05;
  localparam logic [7:0] OP_READ_STATUS2  = 8'h35;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_SUSPEND       = 8'h75;
  localparam logic [7:0] OP_RESUME        = 8'h7a;
  localparam logic [7:0] OP_POWER_DOWN    = 8'hb9;
  localparam logic [7:0] OP_WAKE          = 8'hab;
  localparam logic [7:0] OP_FOUR_WIRE_ON  = 8'h38;
  localparam logic [7:0] OP_FOUR_WIRE_OFF = 8'hff;
  localparam logic [7:0] OP_RESET_ARM     = 8'h66;
  localparam logic [7:0] OP_RESET_GO      = 8'h99;
  localparam logic [7:0] OP_PARAM_READ    = 8'h5a;
  localparam logic [7:0] OP_QUAD_READ     = 8'heb;
  // Mode byte of the quad read
  localparam logic [3:0] MODE_ENTER_NIBBLE = 4'ha;
  // Status bit positions
  localparam int WIP_BIT = 0;
  localparam int QE_BIT  = 1;
  // Byte positions inside a frame, opcode is byte 0
  localparam int STATUS_DATA_BYTE = 1;
  localparam int ADDR_LAST_BYTE   = 3;
  localparam int STATUS2_BYTE     = 2;
  localparam int QUAD_MODE_BYTE   = 4;
  localparam int PARAM_DATA_BYTE  = 5;
  localparam int QUAD_DATA_BYTE   = 6;
  // Bit counts that close a frame
  localparam logic [15:0] ONE_BYTE_BITS    = 16'h0008;
  localparam logic [15:0] WRITE_STAT_BITS  = 16'h0018;
  localparam logic [15:0] QUAD_MODE_BITS   = 16'h0028;
  // Discoverable parameters at relative addresses 64h..67h
  localparam logic [7:0]  PARAM_BASE = 8'h64;
  localparam logic [31:0] PARAM_WORD = 32'h5cd5a2f7;
  localparam logic [7:0]  PARAM_FILL = 8'hff;
  localparam logic [7:0]  ARRAY_FILL = 8'hff;
  // Timing
  localparam int SYS_CLK_NS   = 10;
  localparam int WAKE_NS      = 3000;
  localparam int WAKE_CYC     = (WAKE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int SCLK_HALF    = 8;
  localparam int CS_GAP_TICKS = 2;
  localparam int OP_CYCLES    = 1000;
  // Host register map
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_TX0      = 8'h04;
  localparam logic [7:0] REG_TX1      = 8'h08;
  localparam logic [7:0] REG_RX       = 8'h0c;
  localparam logic [7:0] REG_STATE    = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h18;
  localparam logic [7:0] REG_IRQ_EN   = 8'h1c;
  // Control register fields
  localparam int CTRL_NTX_LSB  = 8;
  localparam int CTRL_NRX_LSB  = 11;
  localparam int CTRL_QUAD_BIT = 14;
  localparam int CTRL_FOUR_BIT = 15;
  localparam int CTRL_SKIP_BIT = 16;
  localparam int CTRL_POLL_BIT = 17;
  localparam int CTRL_MRST_BIT = 18;
  // Interrupt bits and reset values
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Host sequencer states
  typedef enum {H_IDLE, H_RUN, H_GAP, H_GUARD} host_state_t;
endpackage
`default_nettype wire
